/* File: src/sai_pkg.sv */
// shared constants, types and register map of the sa-bit interrupt block
package sai_pkg;

    // -------------------------------------------------------------------
    // bus and channel geometry
    // -------------------------------------------------------------------
    localparam int          NUM_CHAN_DEF = 8;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          CHAN_LSB     = 4;

    // -------------------------------------------------------------------
    // register offsets inside one channel window
    // -------------------------------------------------------------------
    localparam logic [3:0]  OFS_SA_STAT  = 4'h0;
    localparam logic [3:0]  OFS_SA_EN    = 4'h4;
    localparam logic [3:0]  OFS_ZS_STAT  = 4'h8;
    localparam logic [3:0]  OFS_ZS_EN    = 4'hc;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int          BIT_P1111    = 7;
    localparam int          BIT_P1110    = 6;
    localparam int          BIT_P1100    = 5;
    localparam int          BIT_PA       = 4;
    localparam int          BIT_PB       = 3;
    localparam int          BIT_PC       = 2;
    localparam int          BIT_OTHER    = 1;
    localparam int          BIT_PZERO    = 0;
    localparam int          BIT_S7STATE  = 5;
    localparam int          BIT_S7CHG    = 1;
    localparam int          BIT_ZRCHG    = 0;
    localparam logic [7:0]  ZS_EN_MASK   = 8'h03;
    localparam logic [7:0]  ZS_ST_MASK   = 8'h03;

    // -------------------------------------------------------------------
    // monitored nibble values
    // -------------------------------------------------------------------
    localparam logic [3:0]  PAT_1111     = 4'hf;
    localparam logic [3:0]  PAT_1110     = 4'he;
    localparam logic [3:0]  PAT_1100     = 4'hc;
    localparam logic [3:0]  PAT_A        = 4'ha;
    localparam logic [3:0]  PAT_B        = 4'h8;
    localparam logic [3:0]  PAT_C        = 4'h2;
    localparam logic [3:0]  PAT_C_MASK   = 4'he;
    localparam logic [3:0]  PAT_ZERO     = 4'h0;
    localparam logic [7:0]  BOTH_EDGE    = 8'hfd;

    // -------------------------------------------------------------------
    // reset values and counts
    // -------------------------------------------------------------------
    localparam logic [7:0]  EN_RST       = 8'h00;
    localparam logic [7:0]  ST_RST       = 8'h00;
    localparam int          DEB_REPEAT   = 2;
    localparam logic [2:0]  VOTE_RST     = 3'h7;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_DONE = 1'b1
    } sai_apb_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } sai_apb_req_s;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } sai_apb_rsp_s;

    typedef struct packed {
        logic       sa6Valid;
        logic [3:0] sa6Nibble;
        logic       sa7Valid;
        logic       sa7Bit;
        logic       zeroRun;
    } sai_rx_s;

endpackage : sai_pkg

/* File: src/sai_sa6_debounce.sv */
// debounce of the received national-bit nibble over consecutive multiframes
`timescale 1ns/10ps
`default_nettype none
module sai_sa6_debounce #(
    parameter int REPEAT = sai_pkg::DEB_REPEAT
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // one nibble per multiframe
    input  wire logic       sampleValid,
    input  wire logic [3:0] sampleNibble,
    // debounced result
    output logic      [3:0] debNibble,
    output logic            debValid
);
    import sai_pkg::*;

    localparam int             CNT_W   = $clog2(REPEAT + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(REPEAT);

    logic [3:0]       last_q, last_d, deb_q, deb_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             valid_q, valid_d;

    always_comb begin
        last_d  = last_q;
        cnt_d   = cnt_q;
        deb_d   = deb_q;
        valid_d = valid_q;
        if (sampleValid) begin
            if (sampleNibble == last_q && cnt_q != '0) begin
                if (cnt_q != CNT_MAX) begin
                    cnt_d = cnt_q + 1'b1;
                end
            end else begin
                last_d = sampleNibble;
                cnt_d  = CNT_W'(1);
            end
            if (cnt_d == CNT_MAX) begin
                deb_d   = sampleNibble;
                valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_q  <= 4'h0;
            cnt_q   <= '0;
            deb_q   <= 4'h0;
            valid_q <= 1'b0;
        end else begin
            last_q  <= last_d;
            cnt_q   <= cnt_d;
            deb_q   <= deb_d;
            valid_q <= valid_d;
        end
    end

    assign debNibble = deb_q;
    assign debValid  = valid_q;

    property p_deb_repeat;
        @(posedge core_clk) disable iff (rst)
        (sampleValid && cnt_q != '0 && sampleNibble == last_q && cnt_q == CNT_MAX - 1'b1)
            |=> (debValid && debNibble == $past(sampleNibble));
    endproperty
    a_deb_repeat: assert property (p_deb_repeat) else $error("debounce missed repeat");

    property p_deb_cause;
        @(posedge core_clk) disable iff (rst)
        $changed(debNibble) |-> $past(sampleValid);
    endproperty
    a_deb_cause: assert property (p_deb_cause) else $error("debounce moved unprompted");

endmodule : sai_sa6_debounce
`default_nettype wire

/* File: src/sai_sa7_vote.sv */
// two-out-of-three vote for a received spare bit equal to zero
`timescale 1ns/10ps
`default_nettype none
module sai_sa7_vote (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // one bit per observation
    input  wire logic sampleValid,
    input  wire logic sampleBit,
    // vote result
    output logic      lowState
);
    import sai_pkg::*;

    logic [2:0] hist_q, hist_d;
    logic       state_q, state_d;

    always_comb begin
        hist_d  = hist_q;
        state_d = state_q;
        if (sampleValid) begin
            hist_d  = {hist_q[1:0], sampleBit};
            state_d = (hist_d[0] | hist_d[1]) ? (~hist_d[0] & ~hist_d[1]) |
                      ((hist_d[0] ^ hist_d[1]) & ~hist_d[2]) : 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hist_q  <= VOTE_RST;
            state_q <= 1'b0;
        end else begin
            hist_q  <= hist_d;
            state_q <= state_d;
        end
    end

    assign lowState = state_q;

    property p_vote_set;
        @(posedge core_clk) disable iff (rst)
        (sampleValid && !sampleBit && hist_q[1:0] != 2'b11) |=> lowState;
    endproperty
    a_vote_set: assert property (p_vote_set) else $error("zero vote not declared");

    property p_vote_clr;
        @(posedge core_clk) disable iff (rst)
        (sampleValid && sampleBit && hist_q[1:0] != 2'b00) |=> !lowState;
    endproperty
    a_vote_clr: assert property (p_vote_clr) else $error("zero vote not withdrawn");

endmodule : sai_sa7_vote
`default_nettype wire

/* File: src/sai_sa_irq.sv */
// per-channel sa-bit change detection with enable and clear-on-read status over apb
`timescale 1ns/10ps
`default_nettype none
module sai_sa_irq #(
    parameter int NUM_CHAN = sai_pkg::NUM_CHAN_DEF,
    parameter int REPEAT   = sai_pkg::DEB_REPEAT
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // apb slave
    input  wire sai_pkg::sai_apb_req_s  apbReq,
    output      sai_pkg::sai_apb_rsp_s  apbRsp,
    // receive framer national-bit feed, one per channel
    input  wire sai_pkg::sai_rx_s [NUM_CHAN-1:0] rxIn
);
    import sai_pkg::*;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [7:0]   saEn_q   [NUM_CHAN];
    logic [7:0]   saEn_d   [NUM_CHAN];
    logic [7:0]   saSt_q   [NUM_CHAN];
    logic [7:0]   saSt_d   [NUM_CHAN];
    logic [7:0]   zsEn_q   [NUM_CHAN];
    logic [7:0]   zsEn_d   [NUM_CHAN];
    logic [7:0]   zsSt_q   [NUM_CHAN];
    logic [7:0]   zsSt_d   [NUM_CHAN];
    logic [7:0]   mPrev_q  [NUM_CHAN];
    logic [7:0]   mPrev_d  [NUM_CHAN];
    logic         s7Prev_q [NUM_CHAN];
    logic         s7Prev_d [NUM_CHAN];
    logic         zrPrev_q [NUM_CHAN];
    logic         zrPrev_d [NUM_CHAN];
    logic [7:0]   match    [NUM_CHAN];
    logic [7:0]   saSet    [NUM_CHAN];
    logic [7:0]   zsSet    [NUM_CHAN];
    logic         s7State  [NUM_CHAN];
    sai_apb_e     phase_q, phase_d;
    sai_apb_rsp_s rsp_q, rsp_d;

    // -------------------------------------------------------------------
    // per-channel detectors
    // -------------------------------------------------------------------
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        logic [3:0] deb;
        logic       debOk;

        sai_sa6_debounce #(
            .REPEAT      (REPEAT)
        ) u_deb (
            .core_clk    (core_clk),
            .rst         (rst),
            .sampleValid (rxIn[c].sa6Valid),
            .sampleNibble(rxIn[c].sa6Nibble),
            .debNibble   (deb),
            .debValid    (debOk)
        );

        sai_sa7_vote u_vote (
            .core_clk    (core_clk),
            .rst         (rst),
            .sampleValid (rxIn[c].sa7Valid),
            .sampleBit   (rxIn[c].sa7Bit),
            .lowState    (s7State[c])
        );

        // patterns on bits 7 to 0
        assign match[c][BIT_P1111] = debOk && deb == PAT_1111;
        assign match[c][BIT_P1110] = debOk && deb == PAT_1110;
        assign match[c][BIT_P1100] = debOk && deb == PAT_1100;
        assign match[c][BIT_PA]    = debOk && deb == PAT_A;
        assign match[c][BIT_PB]    = debOk && deb == PAT_B;
        assign match[c][BIT_PC]    = debOk && (deb & PAT_C_MASK) == PAT_C;
        assign match[c][BIT_PZERO] = debOk && deb == PAT_ZERO;
        assign match[c][BIT_OTHER] = debOk && ((match[c] & BOTH_EDGE) == 8'h00);

        assign saSet[c] = (((match[c] ^ mPrev_q[c]) & BOTH_EDGE) |
                           (match[c] & ~mPrev_q[c] & ~BOTH_EDGE)) & saEn_q[c];
        assign zsSet[c] = {6'h00, s7State[c] ^ s7Prev_q[c],
                           rxIn[c].zeroRun ^ zrPrev_q[c]} & zsEn_q[c];
    end

    // -------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------
    // channel index sized to the array so up to sixteen channels decode without aliasing
    localparam int CH_W = (NUM_CHAN > 1) ? $clog2(NUM_CHAN) : 1;

    logic [3:0]      chan, ofs;
    logic [CH_W-1:0] chanIx;
    logic            chanOk, ofsOk, access;

    assign chan   = apbReq.paddr[CHAN_LSB +: 4];
    assign ofs    = apbReq.paddr[3:0];
    assign chanIx = chan[CH_W-1:0];
    assign chanOk = {28'h0, chan} < 32'(NUM_CHAN);
    assign ofsOk  = ofs == OFS_SA_STAT || ofs == OFS_SA_EN ||
                    ofs == OFS_ZS_STAT || ofs == OFS_ZS_EN;
    assign access = apbReq.psel && apbReq.penable;

    function automatic logic [7:0] rd_word(input logic [7:0] saEn, input logic [7:0] saSt,
                                           input logic [7:0] zsEn, input logic [7:0] zsSt,
                                           input logic       s7, input logic [3:0] o);
        logic [7:0] v;
        v = 8'h00;
        unique case (o)
            OFS_SA_STAT: v = saSt;
            OFS_SA_EN:   v = saEn;
            OFS_ZS_STAT: v = (zsSt & ZS_ST_MASK) | (8'(s7) << BIT_S7STATE);
            OFS_ZS_EN:   v = zsEn & ZS_EN_MASK;
            default:     v = 8'h00;
        endcase
        return v;
    endfunction : rd_word

    // -------------------------------------------------------------------
    // bus response: one wait state, answer registered
    // -------------------------------------------------------------------
    always_comb begin
        phase_d = phase_q;
        rsp_d   = rsp_q;
        unique case (phase_q)
            APB_IDLE: begin
                if (access) begin
                    phase_d        = APB_DONE;
                    rsp_d.pready   = 1'b1;
                    rsp_d.pslverr  = !(chanOk && ofsOk);
                    rsp_d.prdata   = '0;
                    if (chanOk && !apbReq.pwrite) begin
                        rsp_d.prdata[7:0] = rd_word(saEn_q[chanIx], saSt_q[chanIx],
                                                    zsEn_q[chanIx], zsSt_q[chanIx],
                                                    s7State[chanIx], ofs);
                    end
                end
            end
            APB_DONE: begin
                phase_d      = APB_IDLE;
                rsp_d.pready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_q <= APB_IDLE;
            rsp_q   <= '0;
        end else begin
            phase_q <= phase_d;
            rsp_q   <= rsp_d;
        end
    end

    assign apbRsp = rsp_q;

    // -------------------------------------------------------------------
    // registers: enables, sticky flags, edge history
    // -------------------------------------------------------------------
    logic commit, wrOk;
    assign commit = phase_q == APB_DONE && access && !rsp_q.pslverr;
    assign wrOk   = commit && apbReq.pwrite;

    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            logic       sel;
            logic [7:0] saClr, zsClr;
            sel   = commit && chan == 4'(c);
            saClr = 8'h00;
            zsClr = 8'h00;
            saEn_d[c]   = saEn_q[c];
            zsEn_d[c]   = zsEn_q[c];
            mPrev_d[c]  = match[c];
            s7Prev_d[c] = s7State[c];
            zrPrev_d[c] = rxIn[c].zeroRun;
            if (sel && wrOk) begin
                if (ofs == OFS_SA_EN) begin
                    saEn_d[c] = apbReq.pwdata[7:0];
                end
                if (ofs == OFS_ZS_EN) begin
                    zsEn_d[c] = apbReq.pwdata[7:0] & ZS_EN_MASK;
                end
                if (ofs == OFS_SA_STAT) begin
                    saClr = apbReq.pwdata[7:0];
                end
                if (ofs == OFS_ZS_STAT) begin
                    zsClr = apbReq.pwdata[7:0];
                end
            end
            if (sel && !apbReq.pwrite && ofs == OFS_SA_STAT) begin
                saClr = rsp_q.prdata[7:0];
            end
            if (sel && !apbReq.pwrite && ofs == OFS_ZS_STAT) begin
                zsClr = rsp_q.prdata[7:0];
            end
            saSt_d[c] = (saSt_q[c] & ~saClr) | saSet[c];
            zsSt_d[c] = ((zsSt_q[c] & ~zsClr) | zsSet[c]) & ZS_ST_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (rst) begin
                saEn_q[c]   <= EN_RST;
                zsEn_q[c]   <= EN_RST;
                saSt_q[c]   <= ST_RST;
                zsSt_q[c]   <= ST_RST;
                mPrev_q[c]  <= 8'h00;
                s7Prev_q[c] <= 1'b0;
                zrPrev_q[c] <= 1'b0;
            end else begin
                saEn_q[c]   <= saEn_d[c];
                zsEn_q[c]   <= zsEn_d[c];
                saSt_q[c]   <= saSt_d[c];
                zsSt_q[c]   <= zsSt_d[c];
                mPrev_q[c]  <= mPrev_d[c];
                s7Prev_q[c] <= s7Prev_d[c];
                zrPrev_q[c] <= zrPrev_d[c];
            end
        end
    end

    // -------------------------------------------------------------------
    // checks on the bus and on channel 0
    // -------------------------------------------------------------------
    logic rdSt0, rdZs0;
    assign rdSt0 = commit && !apbReq.pwrite && chan == 4'h0 && ofs == OFS_SA_STAT;
    assign rdZs0 = phase_q == APB_IDLE && access && !apbReq.pwrite &&
                   chan == 4'h0 && ofs == OFS_ZS_STAT;

    sequence s_ack;
        rsp_q.pready ##1 !rsp_q.pready;
    endsequence

    property p_apb_ack;
        @(posedge core_clk) disable iff (rst)
        (phase_q == APB_IDLE && access) |=> s_ack;
    endproperty
    a_apb_ack: assert property (p_apb_ack) else $error("apb answer not one cycle");

    property p_rur;
        @(posedge core_clk) disable iff (rst)
        (rdSt0 && saSet[0] == 8'h00) |=> (saSt_q[0] & $past(rsp_q.prdata[7:0])) == 8'h00;
    endproperty
    a_rur: assert property (p_rur) else $error("status not cleared by read");

    property p_gate;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> (saSt_q[0] & ~$past(saSt_q[0]) & ~$past(saEn_q[0])) == 8'h00;
    endproperty
    a_gate: assert property (p_gate) else $error("flag set while disabled");

    property p_edge;
        @(posedge core_clk) disable iff (rst)
        (((match[0] ^ mPrev_q[0]) & BOTH_EDGE & saEn_q[0]) != 8'h00)
            |=> (saSt_q[0] & $past((match[0] ^ mPrev_q[0]) & BOTH_EDGE & saEn_q[0])) != 8'h00;
    endproperty
    a_edge: assert property (p_edge) else $error("pattern change not latched");

    property p_other;
        @(posedge core_clk) disable iff (rst)
        (match[0][BIT_OTHER] && !mPrev_q[0][BIT_OTHER] && saEn_q[0][BIT_OTHER])
            |=> saSt_q[0][BIT_OTHER];
    endproperty
    a_other: assert property (p_other) else $error("other value not latched");

    property p_s7_read;
        @(posedge core_clk) disable iff (rst)
        rdZs0 |=> rsp_q.prdata[BIT_S7STATE] == $past(s7State[0]);
    endproperty
    a_s7_read: assert property (p_s7_read) else $error("spare7 state misread");

    property p_zr;
        @(posedge core_clk) disable iff (rst)
        (rxIn[0].zeroRun != zrPrev_q[0] && zsEn_q[0][BIT_ZRCHG]) |=> zsSt_q[0][BIT_ZRCHG];
    endproperty
    a_zr: assert property (p_zr) else $error("zero-run change lost");

endmodule : sai_sa_irq
`default_nettype wire

/* File: tb/sai_rx_model.sv */
// receive framer model feeding national-bit samples to each channel
`timescale 1ns/10ps
`default_nettype none
module sai_rx_model #(
    parameter int NUM_CHAN = 2
) (
    // clock
    input  wire logic                            core_clk,
    // framer feed
    output var  sai_pkg::sai_rx_s [NUM_CHAN-1:0] rxOut
);
    import sai_pkg::*;

    initial rxOut = '0;

    // ---------------------------------------------------------------
    // framer actions
    // ---------------------------------------------------------------
    // data lines show the inverse between pulses so stale values never match
    task automatic nib(input int c, input logic [3:0] n, input int reps);
        repeat (reps) begin
            rxOut[c].sa6Valid  <= 1'b1;
            rxOut[c].sa6Nibble <= n;
            @(posedge core_clk);
            rxOut[c].sa6Valid  <= 1'b0;
            rxOut[c].sa6Nibble <= ~n;
            @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
    endtask : nib

    task automatic s7(input int c, input logic b);
        rxOut[c].sa7Valid <= 1'b1;
        rxOut[c].sa7Bit   <= b;
        @(posedge core_clk);
        rxOut[c].sa7Valid <= 1'b0;
        rxOut[c].sa7Bit   <= ~b;
        repeat (4) @(posedge core_clk);
    endtask : s7

    task automatic zr(input int c, input logic v);
        rxOut[c].zeroRun <= v;
        repeat (4) @(posedge core_clk);
    endtask : zr
endmodule : sai_rx_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the sa-bit interrupt block over apb
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sai_pkg::*;
    localparam int NCH = 2;

    logic              core_clk    = 1'b0;
    logic              rst         = 1'b1;
    sai_apb_req_s      apbReq      = '0;
    sai_apb_rsp_s      apbRsp;
    sai_rx_s [NCH-1:0] rxIn;
    int                mismatches  = 0;
    int                comparisons = 0;
    int                cycles      = 0;
    logic [7:0]        pv;
    logic [7:0]        nm;
    logic [7:0]        ex;
    logic [3:0]        seq [10]    = '{4'ha, 4'h8, 4'h2, 4'h0, 4'hf, 4'he, 4'hc, 4'h5, 4'h3, 4'h2};
    logic              s7b [4]     = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0]        s7x [4]     = '{8'h00, 8'h22, 8'h20, 8'h02};

    always #5 core_clk = ~core_clk;

    sai_sa_irq #(.NUM_CHAN(NCH), .REPEAT(2)) sai_sa_irq_i (
        .core_clk(core_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .rxIn(rxIn));
    sai_rx_model #(.NUM_CHAN(NCH)) sai_rx_model_i (.core_clk(core_clk), .rxOut(rxIn));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; read data is only checked on reads
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                       input logic [7:0] exd, input logic err);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, wd}};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        do @(posedge core_clk); while (apbRsp.pready !== 1'b1);
        if (!wr) chk("prdata", {24'h0, exd}, apbRsp.prdata);
        chk("pslverr", {31'h0, err}, {31'h0, apbRsp.pslverr});
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge core_clk);
    endtask : acc

    function automatic logic [7:0] pm(input logic [3:0] n);
        case (n)
            PAT_1111: return 8'h80;
            PAT_1110: return 8'h40;
            PAT_1100: return 8'h20;
            PAT_A:    return 8'h10;
            PAT_B:    return 8'h08;
            PAT_ZERO: return 8'h01;
            default:  return ((n & PAT_C_MASK) == PAT_C) ? 8'h04 : 8'h02;
        endcase
    endfunction : pm

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int a = 0; a < 32; a += 4) acc(0, 8'(a), 0, 8'h00, 0);
        acc(1, 8'h04, 8'hff, 0, 0);
        acc(1, 8'h14, 8'h21, 0, 0);
        acc(1, 8'h0c, 8'hff, 0, 0);
        acc(1, 8'h05, 8'h00, 0, 1);
        acc(0, 8'h24, 0, 8'h00, 1);
        acc(0, 8'h04, 0, 8'hff, 0);
        acc(0, 8'h14, 0, 8'h21, 0);
        acc(0, 8'h0c, 0, 8'h03, 0);
        pv = 8'h00;
        foreach (seq[i]) begin
            sai_rx_model_i.nib(0, seq[i], 2);
            nm = pm(seq[i]);
            ex = (nm == pv) ? 8'h00 : (nm | (pv & BOTH_EDGE));
            acc(0, 8'h00, 0, ex, 0);
            acc(0, 8'h00, 0, 8'h00, 0);
            pv = nm;
        end
        acc(0, 8'h10, 0, 8'h00, 0);
        sai_rx_model_i.nib(0, 4'h0, 1);
        acc(0, 8'h00, 0, 8'h00, 0);
        acc(1, 8'h04, 8'h00, 0, 0);
        sai_rx_model_i.nib(0, 4'hf, 2);
        acc(0, 8'h00, 0, 8'h00, 0);
        acc(1, 8'h04, 8'h80, 0, 0);
        sai_rx_model_i.nib(0, 4'ha, 2);
        acc(0, 8'h00, 0, 8'h80, 0);
        foreach (s7b[i]) begin
            sai_rx_model_i.s7(0, s7b[i]);
            acc(0, 8'h08, 0, s7x[i], 0);
        end
        acc(0, 8'h08, 0, 8'h00, 0);
        sai_rx_model_i.zr(0, 1'b1);
        acc(0, 8'h08, 0, 8'h01, 0);
        sai_rx_model_i.zr(0, 1'b0);
        acc(0, 8'h08, 0, 8'h01, 0);
        sai_rx_model_i.zr(0, 1'b1);
        acc(1, 8'h08, 8'h01, 0, 0);
        acc(0, 8'h08, 0, 8'h00, 0);
        acc(1, 8'h0c, 8'h00, 0, 0);
        sai_rx_model_i.zr(0, 1'b0);
        acc(0, 8'h08, 0, 8'h00, 0);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
